// ===== rtl/dee_ctrl.v
// data eeprom access control: sfr registers, pointer banks, move steering, page buffer, programming
// assumes the cpu core drives one-cycle sfr and move strobes on sys_clk; supply_ok is an async pin
`timescale 1ns/1ps
`include "dee_map.vh"
module dee_ctrl #(
  parameter integer PROG_CYCLES = `DEE_PROG_CYCLES,
  parameter integer PAGE_BYTES = `DEE_PAGE_BYTES
)(
  input wire sys_clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  output reg [7:0] sfr_rdata,
  input wire move_rd,
  input wire move_wr,
  input wire [7:0] move_wdata,
  output reg [7:0] move_rdata,
  output reg move_rvalid,
  output wire [15:0] active_data_pointer,
  output reg ext_rd,
  output reg ext_wr,
  output reg [15:0] ext_addr,
  output reg [7:0] ext_wdata,
  input wire [7:0] ext_rdata,
  input wire supply_ok
);
  localparam integer AW = 11; // eeprom address width, 2048 bytes
  // pages are 32 bytes, so the offset is the low five address bits
  localparam integer PW = 5; // byte offset within one page
  reg [15:0] dpb0_reg; // data_pointer_bank_zero
  reg [15:0] dpb1_reg; // data_pointer_bank_one
  reg load_only_reg;
  reg write_en_reg;
  reg mem_en_reg;
  reg ptr_sel_reg;
  reg [7:0] ee_mem [0:(1<<AW)-1]; // nonvolatile array
  reg [7:0] pbuf_mem [0:PAGE_BYTES-1]; // volatile page buffer
  reg [PAGE_BYTES-1:0] pvalid_reg; // bytes loaded into buffer
  reg [AW-PW-1:0] ppage_reg; // page being programmed
  reg [PW-1:0] last_off_reg; // byte last written, shown while busy
  reg sup_meta_reg; // first synchroniser stage
  reg sup_ok_reg; // synchronised supply good
  wire prog_busy; // timer running
  wire prog_done; // one-cycle completion
  wire prog_start; // launch a programming cycle
  wire ee_busy; // timer running or committing, ready reads low
  wire ee_sel; // move goes on-chip
  wire [AW-1:0] ee_addr;
  integer i;
  // pointer bank selection
  assign active_data_pointer = ptr_sel_reg ? dpb1_reg : dpb0_reg;
  assign ee_addr = active_data_pointer[AW-1:0];
  // full 16-bit compare, so 0800H and up always go outside
  // on-chip only when enabled and address in 000H..7FFH
  assign ee_sel = mem_en_reg && (active_data_pointer <= `DEE_EE_TOP);
  // ready stays low through the commit cycle, so a read once ready is set sees the new bytes
  assign ee_busy = prog_busy || prog_done;
  // a write with load-only clear starts the cycle; busy or low supply refuses it
  assign prog_start = move_wr && ee_sel && write_en_reg && !load_only_reg && !ee_busy && sup_ok_reg;

  // supply pin is asynchronous: two flops before use
  // both stages reset to inhibited, so no cycle starts before the pin is seen
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      sup_meta_reg <= 1'b0;
      sup_ok_reg <= 1'b0;
    end
    else
    begin
      sup_meta_reg <= supply_ok;
      sup_ok_reg <= sup_meta_reg;
    end
  end

  // 24 counter bits hold the 4 ms count at 100 MHz with room to spare
  dee_prog_timer #(
    .CYCLES(PROG_CYCLES),
    .CW(24)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(prog_start),
    .abort(!sup_ok_reg),
    .busy(prog_busy),
    .done(prog_done)
  );

  // sfr writes; ready and inhibit bits are not writable
  // addresses of other sfrs fall through untouched
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      dpb0_reg <= `DEE_ACTIVE_DATA_POINTER_RESET;
      dpb1_reg <= `DEE_ACTIVE_DATA_POINTER_RESET;
      load_only_reg <= 1'b0;
      write_en_reg <= 1'b0;
      mem_en_reg <= 1'b0;
      ptr_sel_reg <= 1'b0;
    end
    else if (sfr_wr)
    begin
      case (sfr_addr)
        `DEE_DPB0_LO_ADDR: dpb0_reg[7:0] <= sfr_wdata;
        `DEE_DPB0_HI_ADDR: dpb0_reg[15:8] <= sfr_wdata;
        `DEE_DPB1_LO_ADDR: dpb1_reg[7:0] <= sfr_wdata;
        `DEE_DPB1_HI_ADDR: dpb1_reg[15:8] <= sfr_wdata;
        `DEE_CTRL_ADDR:
        begin
          load_only_reg <= sfr_wdata[`DEE_LOAD_ONLY_BIT];
          write_en_reg <= sfr_wdata[`DEE_WRITE_EN_BIT];
          mem_en_reg <= sfr_wdata[`DEE_MEM_EN_BIT];
          ptr_sel_reg <= sfr_wdata[`DEE_PTR_SEL_BIT];
        end
        default: ; // other sfrs belong to other blocks
      endcase
    end
  end

  // sfr read mux; unused control bits read zero
  // ready is the inverse of busy; inhibit follows the synchronised pin
  always @*
  begin
    case (sfr_addr)
      `DEE_DPB0_LO_ADDR: sfr_rdata = dpb0_reg[7:0];
      `DEE_DPB0_HI_ADDR: sfr_rdata = dpb0_reg[15:8];
      `DEE_DPB1_LO_ADDR: sfr_rdata = dpb1_reg[7:0];
      `DEE_DPB1_HI_ADDR: sfr_rdata = dpb1_reg[15:8];
      `DEE_CTRL_ADDR: sfr_rdata = {2'b00, load_only_reg, write_en_reg, mem_en_reg, ptr_sel_reg,
                                   !ee_busy, sup_ok_reg};
      default: sfr_rdata = 8'h00;
    endcase
  end

  // page buffer load and commit to the array
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pvalid_reg <= {PAGE_BYTES{1'b0}};
      ppage_reg <= {(AW-PW){1'b0}};
      last_off_reg <= {PW{1'b0}};
    end
    else
    begin
      // loads refused while a cycle runs, so the buffer stays intact
      if (move_wr && ee_sel && write_en_reg && !ee_busy)
      begin
        pbuf_mem[ee_addr[PW-1:0]] <= move_wdata;
        pvalid_reg[ee_addr[PW-1:0]] <= 1'b1;
        last_off_reg <= ee_addr[PW-1:0];
        if (prog_start)
          ppage_reg <= ee_addr[AW-1:PW];
      end
      if (prog_done)
      begin
        // whole loaded page lands at once when the interval ends
        for (i = 0; i < PAGE_BYTES; i = i + 1)
          if (pvalid_reg[i])
            ee_mem[{ppage_reg, i[PW-1:0]}] <= pbuf_mem[i];
        pvalid_reg <= {PAGE_BYTES{1'b0}};
      end
      // limitation: a supply drop during programming loses every byte loaded so far
      else if (prog_busy && !sup_ok_reg)
        pvalid_reg <= {PAGE_BYTES{1'b0}};
    end
  end

  // move reads and external steering, registered: on-chip answer one cycle after the strobe, external data one cycle after ext_rd
  // external data is taken the cycle ext_rd stands; no wait states are supported
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      move_rdata <= 8'h00;
      move_rvalid <= 1'b0;
      ext_rd <= 1'b0;
      ext_wr <= 1'b0;
      ext_addr <= 16'h0000;
      ext_wdata <= 8'h00;
    end
    else
    begin
      move_rvalid <= move_rd && ee_sel;
      ext_rd <= move_rd && !ee_sel;
      ext_wr <= move_wr && !ee_sel;
      if (move_rd || move_wr)
        ext_addr <= active_data_pointer;
      if (move_wr)
        ext_wdata <= move_wdata;
      if (move_rd && ee_sel)
      begin
        if (ee_busy)
          move_rdata <= pbuf_mem[last_off_reg] ^ 8'h80;
        else
          move_rdata <= ee_mem[ee_addr];
      end
      else if (ext_rd)
        move_rdata <= ext_rdata;
    end
  end
endmodule // dee_ctrl

// ===== rtl/dee_map.vh
// register offsets, field positions, reset values and timing counts for the data eeprom control block
// assumes an sfr bus with 8-bit addresses and 8-bit data
`ifndef DEE_MAP_VH
`define DEE_MAP_VH
`define DEE_DPB0_LO_ADDR 8'h82
`define DEE_DPB0_HI_ADDR 8'h83
`define DEE_DPB1_LO_ADDR 8'h84
`define DEE_DPB1_HI_ADDR 8'h85
`define DEE_CTRL_ADDR 8'h96
`define DEE_LOAD_ONLY_BIT 5
`define DEE_WRITE_EN_BIT 4
`define DEE_MEM_EN_BIT 3
`define DEE_PTR_SEL_BIT 2
`define DEE_READY_BIT 1
`define DEE_WINH_BIT 0
`define DEE_CTRL_RESET 8'h03
`define DEE_ACTIVE_DATA_POINTER_RESET 16'h0000
`define DEE_EE_TOP 16'h07FF
`define DEE_PROG_TIME_NS 4000000
`define DEE_CLK_PERIOD_NS 10
`define DEE_PROG_CYCLES (`DEE_PROG_TIME_NS / `DEE_CLK_PERIOD_NS)
`define DEE_PAGE_BYTES 32
`endif

// ===== rtl/dee_prog_timer.v
// self-timed programming interval counter for the data eeprom
// assumes start is a single-cycle pulse on sys_clk; abort may be held high as a level
`timescale 1ns/1ps
module dee_prog_timer #(
  parameter integer CYCLES = 400000,
  parameter integer CW = 20
)(
  input wire sys_clk,
  input wire rst,
  input wire start,
  input wire abort,
  output wire busy,
  output reg done
);
  reg [CW-1:0] cnt_reg; // cycles left in the programming interval
  reg run_reg; // interval in progress
  assign busy = run_reg;
  // count down; abort wins over everything, start only when idle
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_reg <= {CW{1'b0}};
      run_reg <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        run_reg <= 1'b0;
        cnt_reg <= {CW{1'b0}};
      end
      else if (start && !run_reg)
      begin
        run_reg <= 1'b1;
        cnt_reg <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      end
      else if (run_reg)
      begin
        if (cnt_reg == {CW{1'b0}})
        begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dee_prog_timer

// ===== tb/dee_chk_assertions.sv
// port checks for the data eeprom control block
// bound to dee_ctrl; bench parks sfr_addr at 96H
`timescale 1ns/1ps
module dee_chk(
  input logic sys_clk,
  input logic rst,
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_wdata,
  input logic sfr_wr,
  input logic [7:0] sfr_rdata,
  input logic move_rd,
  input logic move_wr,
  input logic [7:0] move_wdata,
  input logic move_rvalid,
  input logic [15:0] active_data_pointer,
  input logic ext_rd,
  input logic ext_wr,
  input logic [15:0] ext_addr,
  input logic [7:0] ext_wdata,
  input logic supply_ok
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire c = sfr_addr == 8'h96; // control on read bus
  wire [7:0] r = sfr_rdata;
  wire ee = active_data_pointer <= 16'h07FF;
  // eeprom write while ready and supply good
  sequence wr_try;
    c && r[3] && r[1] && r[0] && move_wr && ee;
  endsequence
  prog_start_a: assert property (wr_try ##0 r[4] && !r[5] |=> (!c || !r[1])[*8])
    else $error("ready not low after write");
  no_wen_a: assert property (wr_try ##0 !r[4] |=> !c || r[1])
    else $error("write without enable started");
  load_only_a: assert property (wr_try ##0 r[4] && r[5] |=> !c || r[1])
    else $error("load-only write started");
  ro_ready_a: assert property (sfr_wr && c && r[1] && !move_wr |=> !c || r[1])
    else $error("ready bit written");
  ctl_wr_a: assert property (sfr_wr && c |=> !c || (r[5:2] == $past(sfr_wdata[5:2]) && r[7:6] == 2'b00))
    else $error("control layout wrong");
  ext_rt_a: assert property (move_rd && c && !r[3] |=> ext_rd && ext_addr == $past(active_data_pointer))
    else $error("read not sent outside");
  ee_rd_a: assert property (move_rvalid |-> $past(move_rd) && $past(active_data_pointer) <= 16'h07FF)
    else $error("eeprom answer out of range");
  ext_wr_a: assert property (ext_wr |-> $past(move_wr) && ext_wdata == $past(move_wdata))
    else $error("external write mismatch");
  winh_a: assert property (!supply_ok [*3] |-> !c || !r[0])
    else $error("inhibit flag not cleared");
endmodule // dee_chk

// ===== tb/dee_xmem.sv
// external data memory model
// assumes registered ext strobes, answers reads at once
`timescale 1ns/1ps
module dee_xmem(
  input logic sys_clk,
  input logic ext_rd,
  input logic ext_wr,
  input logic [15:0] ext_addr,
  input logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata
);
  logic [7:0] mem [0:255]; // low byte decode only
  logic [7:0] tog = 8'h00; // churns so idle bus never looks valid
  // store writes
  always @(posedge sys_clk)
  begin
    tog <= tog + 8'h01;
    if (ext_wr)
      mem[ext_addr[7:0]] <= ext_wdata;
  end
  assign ext_rdata = ext_rd ? mem[ext_addr[7:0]] : tog;
endmodule // dee_xmem

// ===== tb/testbench.sv
// self-checking bench for the eeprom control block
// assumes dee_ctrl with a short programming count
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0, rst = 1, sfr_wr = 0, move_rd = 0, move_wr = 0, supply_ok = 1;
  logic [7:0] sfr_addr = 8'h96, sfr_wdata = 8'h00, move_wdata = 8'h00;
  logic [7:0] sfr_rdata, move_rdata, ext_rdata, ext_wdata;
  logic move_rvalid, ext_rd, ext_wr;
  logic [15:0] active_data_pointer, ext_addr;
  int n_mismatch = 0, cmp_count = 0, n;
  // control, pointer, byte
  logic [31:0] rows [4] = '{32'h18_0000_A5, 32'h1C_07FF_3C, 32'h18_0800_5A, 32'h10_0010_C3};
  localparam int PROG = 20; // short programming count for simulation
  always #5 sys_clk = ~sys_clk;
  dee_ctrl #(.PROG_CYCLES(PROG)) u_dut(
    .sys_clk(sys_clk),
    .rst(rst),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rdata(sfr_rdata),
    .move_rd(move_rd),
    .move_wr(move_wr),
    .move_wdata(move_wdata),
    .move_rdata(move_rdata),
    .move_rvalid(move_rvalid),
    .active_data_pointer(active_data_pointer),
    .ext_rd(ext_rd),
    .ext_wr(ext_wr),
    .ext_addr(ext_addr),
    .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata),
    .supply_ok(supply_ok)
  );
  dee_xmem u_mem(
    .sys_clk(sys_clk),
    .ext_rd(ext_rd),
    .ext_wr(ext_wr),
    .ext_addr(ext_addr),
    .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata)
  );
  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one strobe, then park on control
  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(posedge sys_clk);
    #1;
    sfr_wr = 0;
    sfr_addr = 8'h96;
  endtask
  task automatic setp(input logic b, input logic [15:0] v);
    sfr(b ? 8'h84 : 8'h82, v[7:0]);
    sfr(b ? 8'h85 : 8'h83, v[15:8]);
  endtask
  task automatic mv(input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    move_wr = w;
    move_rd = !w;
    move_wdata = d;
    @(posedge sys_clk);
    #1;
    move_wr = 0;
    move_rd = 0;
  endtask
  task automatic wrdy;
    n = 0;
    while (sfr_rdata[1] !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(sfr_rdata[1], 1'b1);
  endtask
  task automatic rd(input logic [15:0] p, input logic [7:0] e);
    setp(0, p);
    mv(0, 8'h00);
    chk(move_rvalid, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(move_rdata, e);
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    summarize;
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(sfr_rdata, 8'h03);
    chk(active_data_pointer, 16'h0000);
    foreach (rows[i])
    begin
      sfr(8'h96, rows[i][31:24]);
      setp(rows[i][26], rows[i][23:8]);
      chk(active_data_pointer, rows[i][23:8]);
      mv(1, rows[i][7:0]);
      wrdy;
      mv(0, 8'h00);
      chk(ext_rd, !rows[i][27] || rows[i][23:8] > 16'h07FF);
      chk(move_rvalid, rows[i][27] && rows[i][23:8] <= 16'h07FF);
      @(posedge sys_clk);
      #1;
      chk(move_rdata, rows[i][7:0]);
    end
    // read-only and unused bits
    sfr(8'h96, 8'hFC);
    chk(sfr_rdata, 8'h3F);
    sfr(8'h96, 8'h08);
    setp(0, 16'h0000);
    mv(1, 8'h11);
    chk(sfr_rdata[1], 1'b1);
    rd(16'h0000, 8'hA5);
    // page: two loads, then the final write
    sfr(8'h96, 8'h38);
    for (int k = 0; k < 2; k++)
    begin
      setp(0, 16'h0040 + k);
      mv(1, 8'h01 + k);
      chk(sfr_rdata[1], 1'b1);
    end
    sfr(8'h96, 8'h18);
    setp(0, 16'h0042);
    mv(1, 8'h03);
    mv(0, 8'h00);
    @(posedge sys_clk);
    #1;
    chk(move_rdata, 8'h83);
    wrdy;
    chk(n, PROG - 2);
    for (int k = 0; k < 3; k++)
      rd(16'h0040 + k, 8'h01 + k);
    // supply drop during programming
    setp(0, 16'h0042);
    mv(1, 8'h77);
    repeat (10) @(posedge sys_clk);
    #1;
    supply_ok = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(sfr_rdata[0], 1'b0);
    chk(sfr_rdata[1], 1'b1);
    // no new cycle while supply is low
    mv(1, 8'h55);
    chk(sfr_rdata[1], 1'b1);
    supply_ok = 1;
    repeat (3) @(posedge sys_clk);
    #1;
    rd(16'h0042, 8'h03);
    // reset in mid-run: control and the active pointer return to reset values
    sfr(8'h96, 8'h1C);
    rst = 1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(sfr_rdata, 8'h03);
    chk(active_data_pointer, 16'h0000);
    summarize;
  end
endmodule // testbench
bind dee_ctrl dee_chk u_chk(
  .sys_clk(sys_clk),
  .rst(rst),
  .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr),
  .sfr_rdata(sfr_rdata),
  .move_rd(move_rd),
  .move_wr(move_wr),
  .move_wdata(move_wdata),
  .move_rvalid(move_rvalid),
  .active_data_pointer(active_data_pointer),
  .ext_rd(ext_rd),
  .ext_wr(ext_wr),
  .ext_addr(ext_addr),
  .ext_wdata(ext_wdata),
  .supply_ok(supply_ok)
);
